/* t2ocd_pkg.sv */
// Purpose: Shared constants and carriers for the immediate command decoder
// Assumes: Host messages arrive already unframed as opcode, operand and data
// Notes:   Widths are fixed; one-hot state codes are written out
package t2ocd_pkg;

  localparam logic [7:0] OP_PAR_WR     = 8'h83;
  localparam logic [7:0] OP_PAR_RD     = 8'h84;
  localparam logic [7:0] OP_ALARM_RD   = 8'h87;
  localparam logic [7:0] OP_POS_RD     = 8'h88;
  localparam logic [7:0] OP_SET_OUT    = 8'h8b;
  localparam logic [7:0] OP_FAULT_CLR  = 8'h8e;
  localparam logic [7:0] OP_STOP_PURGE = 8'h98;
  localparam logic [7:0] OP_QREG_WR    = 8'h9e;
  localparam logic [7:0] OP_QREG_RD    = 8'h9f;
  localparam logic [7:0] OP_QLOAD      = 8'ha1;
  localparam logic [7:0] OP_QSAVE      = 8'ha2;
  localparam logic [7:0] OP_STOP       = 8'ha3;
  localparam logic [7:0] OP_UDP        = 8'hff;

  localparam logic [7:0] FLASH_OFFSET  = 8'h80;
  localparam int         FLASH_BIT     = 7;
  localparam int         LEVEL_BIT     = 7;
  localparam int         NUM_OUTPUTS   = 6;
  localparam logic [6:0] OUT_SEL_LAST  = 7'h05;

  localparam logic [7:0] SEL_ZERO      = 8'h00;
  localparam logic [7:0] SEL_ONE       = 8'h01;

  localparam logic [15:0] UDP_PORT     = 16'h1e5f;

  localparam logic [7:0] IDX_MOVE_ACCEL   = 8'h1e;
  localparam logic [7:0] IDX_NORMAL_DECEL = 8'h1f;
  localparam logic [7:0] IDX_MAX_CURRENT  = 8'h18;

  typedef enum logic [1:0] {
    T2OCD_RD_PARAM = 2'h0,
    T2OCD_RD_ALARM = 2'h1,
    T2OCD_RD_POS   = 2'h2,
    T2OCD_RD_QREG  = 2'h3
  } t2ocd_rd_kind_e;

  typedef enum logic [1:0] {
    T2OCD_IDLE = 2'b01,
    T2OCD_WAIT = 2'b10
  } t2ocd_state_e;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  operand;
    logic [31:0] data;
  } t2ocd_cmd_s;

  typedef struct packed {
    logic        req;
    logic [1:0]  kind;
    logic [7:0]  sel;
  } t2ocd_rd_s;

endpackage

/* t2ocd_out_bank.sv */
// Purpose: Holds the discrete output levels set by immediate output commands
// Assumes: Select codes past the last fitted output are dropped silently
// Notes:   Outputs reset low, the safe idle level for external loads
`timescale 1ns/10ps
module t2ocd_out_bank
  import t2ocd_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   reset_n_in,
  input  wire logic                   set_in,
  input  wire logic [7:0]             code_in,
  output logic      [NUM_OUTPUTS-1:0] level_out
);

  logic [NUM_OUTPUTS-1:0] level_reg;
  logic [NUM_OUTPUTS-1:0] level_next;
  logic [NUM_OUTPUTS-1:0] hit;
  wire  [6:0]             sel       = code_in[6:0];
  wire                    lvl       = ~code_in[LEVEL_BIT];
  wire                    sel_valid = sel <= OUT_SEL_LAST;

  // Codes 00 upward drive high, 80 upward drive low
  assign hit        = (set_in && sel_valid) ? (NUM_OUTPUTS'(1) << sel[2:0]) : '0;
  assign level_next = (level_reg & ~hit) | (hit & {NUM_OUTPUTS{lvl}});
  assign level_out  = level_reg;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      level_reg <= '0;
    end else begin
      level_reg <= level_next;
    end
  end

endmodule

/* t2ocd_decoder.sv */
// Purpose: Decodes binary immediate command messages and drives drive resources
// Assumes: Host and resources share clk_in; reads answer with rd_ack_in
// Notes:   One command at a time; cmd_ready_out is low while a read is pending
//
// Notes on behaviour
// - Opcode 83 writes a 16-bit value into the parameter picked by the index.
// - Index with 0x80 added also stores the write in flash.
// - Opcode 84 returns the 16-bit parameter picked by the index.
// - Opcode 87 returns the alarm history entry picked by the operand.
// - Opcode 88 returns 32-bit position: 0 encoder count, 1 absolute.
// - Opcode 8B drives one output: bits 0-6 select, bit 7 level.
// - Codes 00 upward set high, 80 upward set low, up to 05/85.
// - Opcode 8E clears the fault; motor stays off until enabled again.
// - Opcode 98 stops the move and purges the command buffer.
// - Opcode A3 stops keeping the buffer; operand 0 quick, 1 normal decel.
// - Opcode 9E writes a 16 or 32-bit value to the named queue register.
// - Queue register writes pass unchecked; host sends valid values.
// - Opcode 9F returns the contents of the named queue register.
// - After A1, type 1 commands are stored in the queue, not run.
// - Opcode A2 saves the queue buffer as the numbered segment.
// - Opcode FF operand 0 opens the UDP port and listens.
// - Opcode FF operand 1 closes the UDP port and resets it.
// - Parameter operands are hex indices, e.g. 1E accel, 1F decel.
`timescale 1ns/10ps
module t2ocd_decoder
  import t2ocd_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   reset_n_in,
  input  wire t2ocd_cmd_s             cmd_in,
  input  wire logic                   cmd_valid_in,
  output logic                        cmd_ready_out,
  input  wire logic                   t1_valid_in,
  output logic                        t1_exec_out,
  output logic                        t1_queue_out,
  output logic                        par_wr_out,
  output logic                        par_flash_out,
  output logic [7:0]                  index_out,
  output logic [31:0]                 wr_data_out,
  output logic                        qreg_wr_out,
  output t2ocd_rd_s                   rd_out,
  input  wire logic                   rd_ack_in,
  input  wire logic [31:0]            rd_data_in,
  output logic                        resp_valid_out,
  output logic [31:0]                 resp_data_out,
  output logic [NUM_OUTPUTS-1:0]      dout_out,
  output logic                        fault_clear_out,
  output logic                        stop_out,
  output logic                        stop_purge_out,
  output logic                        stop_normal_decel_out,
  output logic                        qload_active_out,
  output logic                        qsave_out,
  output logic                        udp_open_out,
  output logic                        udp_close_out,
  output logic                        udp_listen_out
);

  function automatic logic op_is(input logic [7:0] op, input logic [7:0] code);
    op_is = (op == code);
  endfunction

  function automatic logic sel_bit(input logic [7:0] operand);
    sel_bit = (operand == SEL_ZERO) || (operand == SEL_ONE);
  endfunction

  t2ocd_state_e state_reg;
  t2ocd_state_e state_next;

  logic         par_wr_reg;
  logic         par_flash_reg;
  logic [7:0]   index_reg;
  logic [31:0]  wr_data_reg;
  logic         qreg_wr_reg;
  t2ocd_rd_s    rd_reg;
  t2ocd_rd_s    rd_next;
  logic         resp_valid_reg;
  logic [31:0]  resp_data_reg;
  logic         fault_clear_reg;
  logic         stop_reg;
  logic         stop_purge_reg;
  logic         stop_normal_decel_reg;
  logic         qload_reg;
  logic         qload_next;
  logic         qsave_reg;
  logic         udp_open_reg;
  logic         udp_close_reg;
  logic         udp_listen_reg;
  logic         udp_listen_next;
  logic         t1_exec_reg;
  logic         t1_queue_reg;
  logic         ready_reg;

  wire [7:0]    op       = cmd_in.opcode;
  wire [7:0]    operand  = cmd_in.operand;
  wire          accept   = cmd_valid_in && ready_reg;
  wire          sel_ok   = sel_bit(operand);

  // Anything not matched below falls through with no effect
  wire          do_par_wr   = accept && op_is(op, OP_PAR_WR);
  wire          do_par_rd   = accept && op_is(op, OP_PAR_RD);
  wire          do_alarm_rd = accept && op_is(op, OP_ALARM_RD);
  wire          do_pos_rd   = accept && op_is(op, OP_POS_RD) && sel_ok;
  wire          do_set_out  = accept && op_is(op, OP_SET_OUT);
  wire          do_fclr     = accept && op_is(op, OP_FAULT_CLR);
  wire          do_spurge   = accept && op_is(op, OP_STOP_PURGE) && sel_ok;
  wire          do_stop     = accept && op_is(op, OP_STOP) && sel_ok;
  wire          do_qreg_wr  = accept && op_is(op, OP_QREG_WR);
  wire          do_qreg_rd  = accept && op_is(op, OP_QREG_RD);
  wire          do_qload    = accept && op_is(op, OP_QLOAD);
  wire          do_qsave    = accept && op_is(op, OP_QSAVE);
  wire          do_udp_open = accept && op_is(op, OP_UDP) && (operand == SEL_ZERO);
  wire          do_udp_cls  = accept && op_is(op, OP_UDP) && (operand == SEL_ONE);
  wire          do_read     = do_par_rd || do_alarm_rd || do_pos_rd || do_qreg_rd;
  wire          do_index    = do_par_wr || do_qreg_wr || do_qsave || do_read;

  // Write index drops the flash offset; reads keep the full operand
  wire [7:0]    wr_index    = operand & ~FLASH_OFFSET;
  wire          wr_flash    = operand[FLASH_BIT];
  wire [7:0]    index_next  = do_par_wr ? wr_index : operand;

  // Fault clear does not touch motor enable; host must re-enable
  wire          fclr_next   = do_fclr;

  // Queue register data passes unchecked; the register sizes it
  wire          qwr_next    = do_qreg_wr;

  // Queue load stays on until the buffer is saved as a segment
  assign qload_next = do_qload ? 1'b1 : (do_qsave ? 1'b0 : qload_reg);

  assign udp_listen_next = do_udp_open ? 1'b1 : (do_udp_cls ? 1'b0 : udp_listen_reg);

  // Read kind chosen from the opcode; the operand selects within it
  wire [1:0]    rd_kind = do_par_rd   ? T2OCD_RD_PARAM :
                          do_alarm_rd ? T2OCD_RD_ALARM :
                          do_pos_rd   ? T2OCD_RD_POS   : T2OCD_RD_QREG;

  assign rd_next.req  = do_read;
  assign rd_next.kind = do_read ? rd_kind : rd_reg.kind;
  assign rd_next.sel  = do_read ? operand : rd_reg.sel;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      T2OCD_IDLE: begin
        if (do_read) begin
          state_next = T2OCD_WAIT;
        end
      end
      T2OCD_WAIT: begin
        if (rd_ack_in) begin
          state_next = T2OCD_IDLE;
        end
      end
    endcase
  end

  wire          ready_next = (state_next == T2OCD_IDLE);
  wire          resp_next  = (state_reg == T2OCD_WAIT) && rd_ack_in;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= T2OCD_IDLE;
      ready_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      ready_reg <= ready_next;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      par_wr_reg    <= 1'b0;
      par_flash_reg <= 1'b0;
      qreg_wr_reg   <= 1'b0;
    end else begin
      par_wr_reg    <= do_par_wr;
      par_flash_reg <= do_par_wr && wr_flash;
      qreg_wr_reg   <= qwr_next;
    end
  end

  // Payload holds between strobes so a slow consumer can latch it late
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_data_reg   <= 32'h0000_0000;
      index_reg     <= 8'h00;
    end else begin
      if (do_par_wr || do_qreg_wr) begin
        wr_data_reg <= do_par_wr ? {16'h0000, cmd_in.data[15:0]} : cmd_in.data;
      end
      if (do_index) begin
        index_reg <= index_next;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_reg         <= '0;
    end else begin
      rd_reg         <= rd_next;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      resp_valid_reg <= 1'b0;
      resp_data_reg  <= 32'h0000_0000;
    end else begin
      resp_valid_reg <= resp_next;
      if (resp_next) begin
        resp_data_reg <= rd_data_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fault_clear_reg       <= 1'b0;
      stop_reg              <= 1'b0;
      stop_purge_reg        <= 1'b0;
    end else begin
      fault_clear_reg <= fclr_next;
      stop_reg        <= do_stop || do_spurge;
      stop_purge_reg  <= do_spurge;
    end
  end

  // Decel choice is a level so the motion side can read it after the pulse
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stop_normal_decel_reg <= 1'b0;
    end else begin
      if (do_stop || do_spurge) begin
        stop_normal_decel_reg <= operand[0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      qload_reg      <= 1'b0;
      qsave_reg      <= 1'b0;
    end else begin
      qload_reg      <= qload_next;
      qsave_reg      <= do_qsave;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      udp_open_reg   <= 1'b0;
      udp_close_reg  <= 1'b0;
      udp_listen_reg <= 1'b0;
    end else begin
      udp_open_reg   <= do_udp_open;
      udp_close_reg  <= do_udp_cls;
      udp_listen_reg <= udp_listen_next;
    end
  end

  // Type 1 commands steer to the queue while loading, else run
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      t1_exec_reg  <= 1'b0;
    end else begin
      t1_exec_reg  <= t1_valid_in && !qload_reg;
    end
  end

  // Exactly one of the two routes fires for each arriving command
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      t1_queue_reg <= 1'b0;
    end else begin
      t1_queue_reg <= t1_valid_in && qload_reg;
    end
  end

  t2ocd_out_bank u_out_bank (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .set_in     (do_set_out),
    .code_in    (operand),
    .level_out  (dout_out)
  );

  assign cmd_ready_out         = ready_reg;
  assign t1_exec_out           = t1_exec_reg;
  assign t1_queue_out          = t1_queue_reg;
  assign par_wr_out            = par_wr_reg;
  assign par_flash_out         = par_flash_reg;
  assign index_out             = index_reg;
  assign wr_data_out           = wr_data_reg;
  assign qreg_wr_out           = qreg_wr_reg;
  assign rd_out                = rd_reg;
  assign resp_valid_out        = resp_valid_reg;
  assign resp_data_out         = resp_data_reg;
  assign fault_clear_out       = fault_clear_reg;
  assign stop_out              = stop_reg;
  assign stop_purge_out        = stop_purge_reg;
  assign stop_normal_decel_out = stop_normal_decel_reg;
  assign qload_active_out      = qload_reg;
  assign qsave_out             = qsave_reg;
  assign udp_open_out          = udp_open_reg;
  assign udp_close_out         = udp_close_reg;
  assign udp_listen_out        = udp_listen_reg;

endmodule

/* t2ocd_res_model.sv */
// Purpose: Resource side model answering decoder read requests
// Assumes: Requests are one-cycle pulses; delay_in set before each read
// Notes:   Read data is inverted every cycle between answers, so a stale value matches only on alternate cycles
`timescale 1ns/10ps
module t2ocd_res_model
  import t2ocd_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire t2ocd_rd_s  req_in,
  input  wire logic [3:0] delay_in,
  output logic            ack_out,
  output logic [31:0]     data_out
);
  logic       busy_reg;
  logic [3:0] cnt_reg;
  wire        fire = (req_in.req && delay_in == 4'h0) || (busy_reg && !req_in.req && cnt_reg == 4'h1);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_reg <= 1'b0;
      cnt_reg  <= 4'h0;
      ack_out  <= 1'b0;
      data_out <= 32'h0;
    end else begin
      ack_out  <= 1'b0;
      data_out <= ~data_out;
      if (req_in.req) begin
        busy_reg <= 1'b1;
        cnt_reg  <= delay_in;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
      if (fire) begin
        busy_reg <= 1'b0;
        ack_out  <= 1'b1;
        data_out <= {8'h5a, 6'h00, req_in.kind, req_in.sel, 8'hc3};
      end
    end
  end
endmodule

/* t2ocd_decoder_props.sv */
// Purpose: Port-level checks on the command decoder
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound into every decoder instance
`timescale 1ns/10ps
module t2ocd_decoder_props
  import t2ocd_pkg::*;
(
  input wire logic                   clk_in,
  input wire logic                   reset_n_in,
  input wire t2ocd_cmd_s             cmd_in,
  input wire logic                   cmd_valid_in,
  input wire logic                   cmd_ready_out,
  input wire logic                   t1_valid_in,
  input wire logic                   t1_exec_out,
  input wire logic                   t1_queue_out,
  input wire logic                   par_wr_out,
  input wire logic                   par_flash_out,
  input wire logic [7:0]             index_out,
  input wire logic [31:0]            wr_data_out,
  input wire logic                   qreg_wr_out,
  input wire t2ocd_rd_s              rd_out,
  input wire logic                   rd_ack_in,
  input wire logic [31:0]            rd_data_in,
  input wire logic                   resp_valid_out,
  input wire logic [31:0]            resp_data_out,
  input wire logic [NUM_OUTPUTS-1:0] dout_out,
  input wire logic                   fault_clear_out,
  input wire logic                   stop_out,
  input wire logic                   stop_purge_out,
  input wire logic                   stop_normal_decel_out,
  input wire logic                   qload_active_out,
  input wire logic                   qsave_out,
  input wire logic                   udp_open_out,
  input wire logic                   udp_close_out,
  input wire logic                   udp_listen_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  wire       acc = cmd_valid_in && cmd_ready_out;
  wire [7:0] op  = cmd_in.opcode;
  wire [7:0] opd = cmd_in.operand;
  wire       sel = opd[7:1] == 7'h00;
  wire       rd  = op inside {OP_PAR_RD, OP_ALARM_RD, OP_QREG_RD} || (op == OP_POS_RD && sel);
  wire       known = rd || op inside {OP_PAR_WR, OP_SET_OUT, OP_FAULT_CLR, OP_STOP_PURGE, OP_QREG_WR, OP_QLOAD,
                                      OP_QSAVE, OP_STOP, OP_UDP};

  chk_par_write: assert property (acc && op == OP_PAR_WR |=> par_wr_out
    && par_flash_out == $past(opd[FLASH_BIT]) && index_out == {1'b0, $past(opd[6:0])}
    && wr_data_out == {16'h0000, $past(cmd_in.data[15:0])}) else $error("parameter write wrong");
  chk_read_req: assert property (acc && rd |=> rd_out.req && !cmd_ready_out && rd_out.sel == $past(opd))
    else $error("read request wrong");
  chk_read_answer: assert property (rd_ack_in && !cmd_ready_out && !rd_out.req
    |=> resp_valid_out && cmd_ready_out && resp_data_out == $past(rd_data_in)) else $error("read answer wrong");
  chk_output_set: assert property (acc && op == OP_SET_OUT && opd[6:0] <= OUT_SEL_LAST
    |=> dout_out[$past(opd[2:0])] == !$past(opd[LEVEL_BIT])) else $error("output level wrong");
  chk_fault_clear: assert property (fault_clear_out == $past(acc && op == OP_FAULT_CLR))
    else $error("fault clear pulse wrong");
  chk_stop_kind: assert property (acc && (op == OP_STOP_PURGE || op == OP_STOP) && sel |=> stop_out
    && stop_purge_out == $past(op == OP_STOP_PURGE) && stop_normal_decel_out == $past(opd[0]))
    else $error("stop wrong");
  chk_qreg_write: assert property (acc && op == OP_QREG_WR
    |=> qreg_wr_out && index_out == $past(opd) && wr_data_out == $past(cmd_in.data)) else $error("queue write wrong");
  chk_t1_route: assert property (t1_valid_in
    |=> t1_queue_out == $past(qload_active_out) && t1_exec_out == !$past(qload_active_out)) else $error("t1 route wrong");
  chk_queue_mode: assert property (acc && (op == OP_QLOAD || op == OP_QSAVE)
    |=> qload_active_out == $past(op == OP_QLOAD) && qsave_out == $past(op == OP_QSAVE)) else $error("queue mode wrong");
  chk_udp_port: assert property (acc && op == OP_UDP && sel |=> udp_listen_out == !$past(opd[0])
    && udp_open_out == !$past(opd[0]) && udp_close_out == $past(opd[0])) else $error("udp control wrong");
  chk_unknown_quiet: assert property (acc && !known |=> !par_wr_out && !qreg_wr_out && !stop_out
    && !rd_out.req && $stable(dout_out) && $stable(udp_listen_out) && $stable(qload_active_out))
    else $error("unknown opcode acted");
endmodule

bind t2ocd_decoder t2ocd_decoder_props u_props (.*);

/* tb.sv */
// Purpose: Self-checking bench for the immediate command decoder
// Assumes: Resource model answers reads after a chosen delay
// Notes:   Outputs are sampled 1 ns after the edge that launched them
`timescale 1ns/10ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb
  import t2ocd_pkg::*;
;
  logic                   clk_in, reset_n_in, cmd_valid_in, t1_valid_in, rd_ack_in;
  logic                   cmd_ready_out, t1_exec_out, t1_queue_out, par_wr_out, par_flash_out, qreg_wr_out;
  logic                   resp_valid_out, fault_clear_out, stop_out, stop_purge_out, stop_normal_decel_out;
  logic                   qload_active_out, qsave_out, udp_open_out, udp_close_out, udp_listen_out;
  logic [3:0]             delay;
  logic [7:0]             index_out;
  logic [31:0]            rd_data_in, wr_data_out, resp_data_out;
  logic [NUM_OUTPUTS-1:0] dout_out, exp_dout;
  t2ocd_cmd_s             cmd_in;
  t2ocd_rd_s              rd_out;
  int                     num_errors, num_checks;

  t2ocd_decoder u_dut (.*);
  t2ocd_res_model u_res (.clk_in, .reset_n_in, .req_in(rd_out), .delay_in(delay), .ack_out(rd_ack_in),
                         .data_out(rd_data_in));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Leaves valid high so commands can follow back to back
  task automatic put(input logic [7:0] op, input logic [7:0] opd, input logic [31:0] dat = 32'h0);
    cmd_in = '{op, opd, dat};
    cmd_valid_in = 1'b1;
    while (!cmd_ready_out) @(posedge clk_in) #1;
    @(posedge clk_in) #1;
  endtask

  task automatic rd_chk(input logic [7:0] op, input logic [7:0] opd, input logic [1:0] kind, input logic [3:0] dly);
    int n;
    delay = dly;
    put(op, opd);
    cmd_valid_in = 1'b0;
    `CHK({rd_out.req, rd_out.kind, cmd_ready_out}, {1'b1, kind, 1'b0})
    n = 0;
    while (resp_valid_out !== 1'b1 && n < 30) begin
      @(posedge clk_in) #1;
      n++;
    end
    `CHK({resp_valid_out, cmd_ready_out, resp_data_out}, {2'b11, 8'h5a, 6'h00, kind, opd, 8'hc3})
  endtask

  task automatic t1(input logic [1:0] exp);
    t1_valid_in = 1'b1;
    @(posedge clk_in) #1;
    t1_valid_in = 1'b0;
    `CHK({t1_exec_out, t1_queue_out}, exp)
  endtask

  task automatic results();
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    reset_n_in = 1'b0;
    cmd_valid_in = 1'b0;
    t1_valid_in = 1'b0;
    cmd_in = '0;
    delay = 4'h0;
    exp_dout = '0;
    repeat (3) @(posedge clk_in);
    #1 reset_n_in = 1'b1;
    put(OP_PAR_WR, IDX_MOVE_ACCEL | FLASH_OFFSET, 32'habcd_1234);
    `CHK({par_wr_out, par_flash_out, index_out, wr_data_out}, {2'b11, IDX_MOVE_ACCEL, 32'h0000_1234})
    put(OP_PAR_WR, IDX_MAX_CURRENT, 32'h5555_0077);
    `CHK({par_wr_out, par_flash_out, index_out, wr_data_out}, {2'b10, IDX_MAX_CURRENT, 32'h0000_0077})
    for (int i = 0; i < 12; i++) begin
      if (i == 6) begin
        put(OP_SET_OUT, 8'h86);
        `CHK(dout_out, exp_dout)
      end
      put(OP_SET_OUT, {i >= 6, 7'(i % 6)});
      exp_dout[i % 6] = i < 6;
      `CHK(dout_out, exp_dout)
    end
    put(OP_FAULT_CLR, 8'h00);
    `CHK({fault_clear_out, stop_out}, 2'b10)
    for (int i = 0; i < 4; i++) begin
      put(i < 2 ? OP_STOP_PURGE : OP_STOP, 8'(i % 2));
      `CHK({stop_out, stop_purge_out, stop_normal_decel_out}, {1'b1, i < 2, i[0]})
    end
    put(OP_QREG_WR, 8'h41, 32'hdead_beef);
    `CHK({qreg_wr_out, index_out, wr_data_out}, {1'b1, 8'h41, 32'hdead_beef})
    put(OP_UDP, SEL_ZERO);
    `CHK({udp_open_out, udp_close_out, udp_listen_out}, 3'b101)
    put(OP_UDP, 8'h02);
    `CHK({udp_open_out, udp_close_out, udp_listen_out}, 3'b001)
    put(OP_UDP, SEL_ONE);
    `CHK({udp_open_out, udp_close_out, udp_listen_out}, 3'b010)
    put(8'h85, 8'h01, 32'hffff_ffff);
    `CHK({par_wr_out, qreg_wr_out, stop_out, rd_out.req, dout_out, qload_active_out}, {4'h0, exp_dout, 1'b0})
    put(OP_POS_RD, 8'h02);
    `CHK({rd_out.req, cmd_ready_out}, 2'b01)
    put(OP_STOP, 8'h02);
    `CHK(stop_out, 1'b0)
    put(OP_QLOAD, 8'h00);
    cmd_valid_in = 1'b0;
    `CHK(qload_active_out, 1'b1)
    t1(2'b01);
    put(OP_QSAVE, 8'h0c);
    cmd_valid_in = 1'b0;
    `CHK({qsave_out, qload_active_out, index_out}, {2'b10, 8'h0c})
    t1(2'b10);
    rd_chk(OP_PAR_RD, IDX_NORMAL_DECEL, 2'h0, 4'h0);
    rd_chk(OP_PAR_RD, 8'h94, 2'h0, 4'h3);
    rd_chk(OP_ALARM_RD, 8'h02, 2'h1, 4'h0);
    rd_chk(OP_POS_RD, SEL_ZERO, 2'h2, 4'h5);
    rd_chk(OP_POS_RD, SEL_ONE, 2'h2, 4'h1);
    rd_chk(OP_QREG_RD, 8'h41, 2'h3, 4'h2);
    results();
  end

  // Whole run needs about 65 cycles
  initial begin
    repeat (2000) @(posedge clk_in);
    num_errors++;
    results();
  end
endmodule
